//--- core/hbfs_pkg.sv
// Constants shared by the half-bridge fault supervisor host controller.
// Assumes a 250 MHz pclk; every cycle count below is derived from it.
package hbfs_pkg;

	// Clock
	localparam int CLK_NS = 4;

	// Times in their own units
	localparam int CLEAR_PULSE_WIDTH_NS = 500;
	localparam int NONOVERLAP_TIME_NS   = 2500;
	localparam int MIN_DRIVE_PULSE_NS   = 1000;
	localparam int STARTUP_HOLD_MS      = 20;

	// Least times, rounded up to whole cycles
	localparam int CLEAR_CYC   = (CLEAR_PULSE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
	localparam int DEAD_CYC    = (NONOVERLAP_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int MIN_CYC     = (MIN_DRIVE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int STARTUP_CYC = (STARTUP_HOLD_MS * 1000000 + CLK_NS - 1) / CLK_NS;

	// Leg timer width, enough for the dead time
	localparam int LEG_CNT_W = 10;

	// APB register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CMD    = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_FAULT  = 8'h0c;

	// CTRL fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_HIGH_BIT   = 1;
	localparam int CTRL_LOW_BIT    = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// CMD fields
	localparam int CMD_CLEAR_BIT = 0;

	// FAULT fields
	localparam int FAULT_VALID_BIT = 8;
	localparam int FAULT_CODE_W    = 6;

	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_WAIT  = 3'b001,
		ST_RUN   = 3'b010,
		ST_CLEAR = 3'b100
	} hbfs_state_t;

endpackage

//--- core/hbfs_leg.sv
// One drive leg: on/off state with minimum pulse and off-age timer.
// Assumes req, permit and kill are synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none

module hbfs_leg #(
	parameter int               CNT_W  = hbfs_pkg::LEG_CNT_W,
	parameter logic [CNT_W-1:0] MIN_C  = CNT_W'(hbfs_pkg::MIN_CYC),
	parameter logic [CNT_W-1:0] DEAD_C = CNT_W'(hbfs_pkg::DEAD_CYC)
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic req,
	input  wire logic permit,
	input  wire logic kill,
	// State
	output logic      drive_reg,
	output logic      dead_ok
);

	logic             drive_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;

	////////////////////////////////////////////////////////////////////////////////
	// Next state; kill beats the minimum pulse since a fault must not wait
	always_comb begin
		drive_next = drive_reg;
		cnt_next   = cnt_reg;
		if (cnt_reg < DEAD_C) begin
			cnt_next = cnt_reg + 1'b1;
		end
		if (kill) begin
			drive_next = 1'b0;
		end else if (drive_reg && !req && cnt_reg >= MIN_C) begin // R18
			drive_next = 1'b0;
		end else if (!drive_reg && req && permit && cnt_reg >= MIN_C) begin // R13
			drive_next = 1'b1;
		end
		if (drive_next != drive_reg) begin
			cnt_next = '0;
		end
	end

	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_reg <= 1'b0;
			cnt_reg   <= DEAD_C;
		end else begin
			drive_reg <= drive_next;
			cnt_reg   <= cnt_next;
		end
	end

	// Off long enough for the other leg to start
	assign dead_ok = !drive_reg && (cnt_reg >= DEAD_C); // R13

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_min_pulse_on: assert property (@(posedge pclk) disable iff (!presetn) // R18
		$fell(drive_reg) && !$past(kill) |-> $past(cnt_reg) >= MIN_C)
		else $error("drive pulse shorter than minimum");

endmodule // hbfs_leg

`default_nettype wire

//--- core/hbfs_host.sv
// Host controller for a half-bridge gate driver: startup hold, clear
// pulses, dead-time spaced drive and fault code capture, over APB.
// Assumes driver fault and spare lines are already synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [R1] Driver turns off and flags desaturation after blanking; host only observes.
// [R2] Driver blanking time is a driver setting, one to nine microseconds.
// [R3] Clear line low clears driver faults; host keeps it high otherwise.
// [R4] Driver latches faults until cleared; contents undefined after power-up.
// [R5] Host pulses clear low at least 500 ns at startup.
// [R6] Optional driver auto reset clears faults after programmable interval.
// [R7] With auto reset the driver works with clear line unconnected.
// [R8] Driver fault modes: lockout, report only, automatic reset.
// [R9] Every driver fault source asserts the combined fault line.
// [R10] After combined fault, host reads spare and side lines as code.
// [R11] Undervoltage or desaturation turns both off, reported per side.
// [R12] Active clamping gives no fault and no lockout.
// [R13] Host spaces high and low turn-on by 2.5 us off time.
// [R14] Combined fault low whenever either side fault line is low.
// [R15] Driver refuses overlap and faults both sides if both on.
// [R16] Host keeps drives inactive 20 ms after power-up.
// [R17] Driver follows drive inputs unless that side is locked out.
// [R18] Host never commands drive pulses shorter than one microsecond; kill (a fault line, enable clear or leaving run) ends an on pulse sooner.
module hbfs_host #(
	parameter int STARTUP_CYC = hbfs_pkg::STARTUP_CYC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Driver pins
	output logic             high_side_drive_in,
	output logic             low_side_drive_in,
	output logic             fault_clear_n,
	input  wire logic        high_side_fault_n,
	input  wire logic        low_side_fault_n,
	input  wire logic        combined_fault_n,
	input  wire logic [3:0]  spare_in
);

	localparam int SW = $clog2(STARTUP_CYC + 1);
	localparam int CW = hbfs_pkg::FAULT_CODE_W;

	// Exact 8-bit address decode, used by reads and writes
	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state so every output can come from a flop
	logic          access;
	logic          done;
	logic          pready_next;
	logic          pslverr_next;
	logic [31:0]   prdata_next;
	logic [2:0]    ctrl_reg;
	logic [2:0]    ctrl_next;
	logic          wr_clear;
	logic          wr_fault_ack;
	logic          mapped;

	assign access = psel && penable && !pready;
	assign done   = psel && penable && pready;
	assign mapped = is_reg(paddr, hbfs_pkg::OFS_CTRL) || is_reg(paddr, hbfs_pkg::OFS_CMD)
		|| is_reg(paddr, hbfs_pkg::OFS_STATUS) || is_reg(paddr, hbfs_pkg::OFS_FAULT);
	assign wr_clear     = done && pwrite && is_reg(paddr, hbfs_pkg::OFS_CMD)
		&& pwdata[hbfs_pkg::CMD_CLEAR_BIT];
	assign wr_fault_ack = done && pwrite && is_reg(paddr, hbfs_pkg::OFS_FAULT)
		&& pwdata[hbfs_pkg::FAULT_VALID_BIT];

	logic             fault_valid_reg;
	logic             fault_valid_next;
	logic [CW-1:0]    fault_code_reg;
	logic [CW-1:0]    fault_code_next;
	hbfs_pkg::hbfs_state_t state_reg;
	hbfs_pkg::hbfs_state_t state_next;

	// Read data and answer
	always_comb begin
		pready_next  = access;
		pslverr_next = access && !mapped;
		prdata_next  = 32'h0;
		ctrl_next    = ctrl_reg;
		if (access && !pwrite) begin
			if (is_reg(paddr, hbfs_pkg::OFS_CTRL)) begin
				prdata_next = {29'h0, ctrl_reg};
			end else if (is_reg(paddr, hbfs_pkg::OFS_STATUS)) begin
				prdata_next = {20'h0, spare_in, combined_fault_n, low_side_fault_n,
					high_side_fault_n, fault_clear_n, low_side_drive_in,
					high_side_drive_in, state_reg == hbfs_pkg::ST_RUN, 1'b0};
			end else if (is_reg(paddr, hbfs_pkg::OFS_FAULT)) begin
				prdata_next = {23'h0, fault_valid_reg, 2'h0, fault_code_reg};
			end
		end
		if (done && pwrite && is_reg(paddr, hbfs_pkg::OFS_CTRL)) begin
			ctrl_next = pwdata[2:0];
		end
	end

	// APB registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0;
			ctrl_reg <= hbfs_pkg::CTRL_RESET;
		end else begin
			pready   <= pready_next;
			pslverr  <= pslverr_next;
			prdata   <= prdata_next;
			ctrl_reg <= ctrl_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer: startup hold with clear pulse, run, software clear pulse
	logic [SW-1:0] cnt_reg;
	logic [SW-1:0] cnt_next;
	logic          clear_n_next;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg + 1'b1;
		case (state_reg)
			hbfs_pkg::ST_WAIT: begin
				if (cnt_reg == SW'(STARTUP_CYC - 1)) begin // R16
					state_next = hbfs_pkg::ST_RUN;
					cnt_next   = '0;
				end
			end
			hbfs_pkg::ST_RUN: begin
				cnt_next = '0;
				if (wr_clear) begin // R3
					state_next = hbfs_pkg::ST_CLEAR;
				end
			end
			hbfs_pkg::ST_CLEAR: begin
				if (cnt_reg == SW'(hbfs_pkg::CLEAR_CYC - 1)) begin // R5
					state_next = hbfs_pkg::ST_RUN;
					cnt_next   = '0;
				end
			end
			default: begin
				state_next = hbfs_pkg::ST_WAIT;
				cnt_next   = '0;
			end
		endcase
		// Low only while clearing; high through normal running so faults hold
		clear_n_next = !(state_next == hbfs_pkg::ST_CLEAR ||
			(state_next == hbfs_pkg::ST_WAIT && cnt_next < SW'(hbfs_pkg::CLEAR_CYC))); // R3 R5
	end

	// Sequencer registers; clear starts low since driver latches are unknown
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg     <= hbfs_pkg::ST_WAIT;
			cnt_reg       <= '0;
			fault_clear_n <= 1'b0;
		end else begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			fault_clear_n <= clear_n_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fault code capture: first code held; a new fault beats the ack
	always_comb begin
		fault_valid_next = fault_valid_reg;
		fault_code_next  = fault_code_reg;
		if (wr_fault_ack) begin
			fault_valid_next = 1'b0;
		end
		if (!combined_fault_n && state_reg == hbfs_pkg::ST_RUN
			&& (!fault_valid_reg || wr_fault_ack)) begin
			fault_valid_next = 1'b1; // R10
			fault_code_next  = {spare_in, high_side_fault_n, low_side_fault_n};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_valid_reg <= 1'b0;
			fault_code_reg  <= '0;
		end else begin
			fault_valid_reg <= fault_valid_next;
			fault_code_reg  <= fault_code_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Drive legs; high wins a tie so both never start together
	logic [1:0] leg_req;
	logic [1:0] leg_permit;
	logic [1:0] leg_drive;
	logic [1:0] leg_dead_ok;
	logic       kill;

	// Any fault line low drops both drives; outside report-only mode the driver has turned off anyway
	assign kill = state_reg != hbfs_pkg::ST_RUN || !ctrl_reg[hbfs_pkg::CTRL_ENABLE_BIT]
		|| !high_side_fault_n || !low_side_fault_n || !combined_fault_n; // R16
	assign leg_req    = {ctrl_reg[hbfs_pkg::CTRL_LOW_BIT], ctrl_reg[hbfs_pkg::CTRL_HIGH_BIT]};
	assign leg_permit = {leg_dead_ok[0] && !leg_req[0], leg_dead_ok[1]}; // R13

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_leg
			hbfs_leg u_leg (
				.pclk      (pclk),
				.presetn   (presetn),
				.req       (leg_req[g]),
				.permit    (leg_permit[g]),
				.kill      (kill),
				.drive_reg (leg_drive[g]),
				.dead_ok   (leg_dead_ok[g])
			);
		end
	endgenerate

	assign high_side_drive_in = leg_drive[0];
	assign low_side_drive_in  = leg_drive[1];

	////////////////////////////////////////////////////////////////////////////////
	// Checks and helper counters
	localparam int CLEAR_C = hbfs_pkg::CLEAR_CYC;
	localparam int DEAD_C  = hbfs_pkg::DEAD_CYC;
	int low_len;
	int hi_off_age;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_len    <= 0;
			hi_off_age <= 0;
		end else begin
			low_len    <= fault_clear_n ? 0 : low_len + 1;
			hi_off_age <= high_side_drive_in ? 0 : (hi_off_age < DEAD_C ? hi_off_age + 1 : DEAD_C);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_startup_quiet: assert property (state_reg == hbfs_pkg::ST_WAIT |-> // R16
		!high_side_drive_in && !low_side_drive_in)
		else $error("drive active during startup hold");
	a_clear_width: assert property ($rose(fault_clear_n) |-> $past(low_len) >= CLEAR_C - 1) // R5
		else $error("clear pulse too short");
	a_clear_idle_high: assert property (state_reg == hbfs_pkg::ST_RUN && // R3
		$past(state_reg) == hbfs_pkg::ST_RUN |-> fault_clear_n)
		else $error("clear low while running");
	a_clear_on_write: assert property (wr_clear && state_reg == hbfs_pkg::ST_RUN |=> // R3
		!fault_clear_n [*8])
		else $error("clear command gave no pulse");
	a_no_overlap: assert property (!(high_side_drive_in && low_side_drive_in)) // R13
		else $error("both drives on");
	a_dead_gap: assert property ($rose(low_side_drive_in) |-> $past(hi_off_age) >= DEAD_C) // R13
		else $error("low side started inside dead time");
	a_fault_capture: assert property (!combined_fault_n && !fault_valid_reg && // R10
		state_reg == hbfs_pkg::ST_RUN |=> fault_valid_reg &&
		fault_code_reg == {$past(spare_in), $past(high_side_fault_n), $past(low_side_fault_n)})
		else $error("fault code not captured");
	a_fault_kills: assert property (!high_side_fault_n || !low_side_fault_n |=> // R17
		!high_side_drive_in && !low_side_drive_in)
		else $error("drive kept on during fault");
	a_apb_answer: assert property (psel && penable && !pready |=> pready)
		else $error("APB answer late");

	c_startup_done: cover property (state_reg == hbfs_pkg::ST_WAIT ##1 state_reg == hbfs_pkg::ST_RUN);
	c_high_on: cover property ($rose(high_side_drive_in));
	c_low_after_high: cover property ($fell(high_side_drive_in) ##[1:1000] $rose(low_side_drive_in));
	c_fault_seen: cover property ($rose(fault_valid_reg));
	c_soft_clear: cover property (state_reg == hbfs_pkg::ST_CLEAR);

endmodule // hbfs_host

`default_nettype wire

//--- testbench/hbfs_drv_model.sv
// Behavioural gate driver standing on the far side of the host controller.
// Assumes drive and clear pins sampled on pclk; fault lines pulled up when idle.
`timescale 1ns/100ps
`default_nettype none

module hbfs_drv_model #(
	parameter logic [3:0] SPARE_CODE = 4'ha,
	parameter logic [1:0] FAULT_MODE = 2'h0,    // 0 lockout, 1 report only, 2 auto reset
	parameter int         AUTO_CYC   = 1250000  // 5 ms of pclk
) (
	// Clock
	input  wire logic       pclk,
	// Host pins
	input  wire logic       high_side_drive_in,
	input  wire logic       low_side_drive_in,
	input  wire logic       fault_clear_n,
	// Fault injection: desaturation seen after blanking, or undervoltage
	input  wire logic       inj_high,
	input  wire logic       inj_low,
	// Fault reporting
	output logic            high_side_fault_n,
	output logic            low_side_fault_n,
	output logic            combined_fault_n,
	output logic [3:0]      spare_out,
	output logic            gate_high,
	output logic            gate_low
);
	////////////////////////////////////////////////////////////////////////////
	// Latches start set, so a host that skips the startup clear sees faults
	logic hf_lat = 1'b1;
	logic lf_lat = 1'b1;
	logic both_on;
	logic lock;
	int   auto_cnt = 0;

	assign both_on = high_side_drive_in & low_side_drive_in;

	// Clear or auto reset wins over new events; overlap faults both sides.
	// Only injected events and overlap set latches; clamping never does
	always @(posedge pclk) begin
		if (!fault_clear_n || (FAULT_MODE == 2'h2 && auto_cnt >= AUTO_CYC)) begin
			hf_lat <= 1'b0;
			lf_lat <= 1'b0;
		end else begin
			if (inj_high || both_on) hf_lat <= 1'b1;
			if (inj_low || both_on) lf_lat <= 1'b1;
		end
	end

	// Age of a latched fault, used by the auto reset mode
	always @(posedge pclk) begin
		auto_cnt <= (hf_lat | lf_lat) ? auto_cnt + 1 : 0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Pins: any latched fault pulls the common line and, outside report-only mode, turns both gates off
	assign high_side_fault_n = ~hf_lat;
	assign low_side_fault_n  = ~lf_lat;
	assign combined_fault_n  = ~(hf_lat | lf_lat);
	assign spare_out         = (hf_lat | lf_lat) ? SPARE_CODE : 4'h0;
	// Report-only mode flags the fault but leaves both gates switching
	assign lock      = (FAULT_MODE != 2'h1) & (hf_lat | lf_lat);
	assign gate_high = high_side_drive_in & ~lock;
	assign gate_low  = low_side_drive_in & ~lock;
endmodule // hbfs_drv_model

`default_nettype wire

//--- testbench/hbfs_host_tb.sv
// Self-checking bench for the host controller against the driver model.
// Assumes an APB slave that answers in its own time; startup hold shortened.
`timescale 1ns/100ps
`default_nettype none

module hbfs_host_tb;
	localparam int START_C = 300;
	// Bench signals
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        inj_high = 1'b0;
	logic        inj_low = 1'b0;
	wire logic   pready, pslverr, hi_d, lo_d, clr_n, hf_n, lf_n, af_n, g_hi, g_lo;
	wire logic [31:0] prdata;
	wire logic [3:0]  spare;
	int          err_count = 0;
	int          total_checks = 0;
	time         t_rel, t_hr, t_hf, t_lr, t_cf, t_cr;
	logic [31:0] rd;
	logic        er;

	////////////////////////////////////////////////////////////////////////////
	// Clock, design and partner
	always #2 pclk = ~pclk;

	hbfs_host #(.STARTUP_CYC(START_C)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.high_side_drive_in(hi_d), .low_side_drive_in(lo_d),
		.fault_clear_n(clr_n), .high_side_fault_n(hf_n),
		.low_side_fault_n(lf_n), .combined_fault_n(af_n), .spare_in(spare));

	hbfs_drv_model #(.SPARE_CODE(4'ha)) drv (.pclk(pclk),
		.high_side_drive_in(hi_d), .low_side_drive_in(lo_d),
		.fault_clear_n(clr_n), .inj_high(inj_high), .inj_low(inj_low),
		.high_side_fault_n(hf_n), .low_side_fault_n(lf_n),
		.combined_fault_n(af_n), .spare_out(spare), .gate_high(g_hi), .gate_low(g_lo));

	// Edge times of the driver pins, for pulse and gap widths
	always @(posedge hi_d) t_hr = $time;
	always @(negedge hi_d) t_hf = $time;
	always @(posedge lo_d) t_lr = $time;
	always @(negedge clr_n) t_cf = $time;
	always @(posedge clr_n) t_cr = $time;

	////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic summarize;
		if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_startup;
		apb(1'b0, hbfs_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, hbfs_pkg::OFS_CTRL, 32'h3);
		chk({31'h0, hi_d}, 32'h0);
		for (int i = 0; i < 2000 && hi_d !== 1'b1; i++) @(posedge pclk);
		chk({31'h0, hi_d}, 32'h1);
		chk(32'((t_cr - t_rel) / 4) >= hbfs_pkg::CLEAR_CYC, 32'h1);
		chk(32'((t_hr - t_rel) / 4) >= START_C, 32'h1);
	endtask

	// Immediate switch request: minimum on time, then dead time before low
	task automatic t_deadtime;
		apb(1'b1, hbfs_pkg::OFS_CTRL, 32'h5);
		for (int i = 0; i < 3000 && lo_d !== 1'b1; i++) @(posedge pclk);
		chk({31'h0, lo_d}, 32'h1);
		chk(32'((t_hf - t_hr) / 4) >= hbfs_pkg::MIN_CYC, 32'h1);
		chk(32'((t_lr - t_hf) / 4) >= hbfs_pkg::DEAD_CYC, 32'h1);
		apb(1'b0, hbfs_pkg::OFS_STATUS, 32'h0);
		chk({25'h0, rd[7:1]}, 32'h7d);
		chk({31'h0, g_lo}, 32'h1);
	endtask

	// Low side fault: both off, code captured, clear pulse, acknowledge
	task automatic t_fault;
		@(posedge pclk);
		inj_low <= 1'b1;
		@(posedge pclk);
		inj_low <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({30'h0, hi_d, lo_d}, 32'h0);
		chk({30'h0, g_hi, g_lo}, 32'h0);
		apb(1'b0, hbfs_pkg::OFS_STATUS, 32'h0);
		chk({29'h0, rd[7:5]}, 32'h1);
		apb(1'b0, hbfs_pkg::OFS_FAULT, 32'h0);
		chk(rd, 32'h12a);
		apb(1'b1, hbfs_pkg::OFS_CTRL, 32'h1);
		apb(1'b1, hbfs_pkg::OFS_CMD, 32'h1);
		// The pulse starts at the accepting edge; let it show before waiting for its end
		@(posedge pclk);
		for (int i = 0; i < 500 && clr_n !== 1'b1; i++) @(posedge pclk);
		chk(32'((t_cr - t_cf) / 4), hbfs_pkg::CLEAR_CYC);
		apb(1'b0, hbfs_pkg::OFS_STATUS, 32'h0);
		chk({29'h0, rd[7:5]}, 32'h7);
		apb(1'b1, hbfs_pkg::OFS_FAULT, 32'h100);
		apb(1'b0, hbfs_pkg::OFS_FAULT, 32'h0);
		chk({31'h0, rd[hbfs_pkg::FAULT_VALID_BIT]}, 32'h0);
	endtask

	// Both requested: high wins, low never starts; disabling drops the drive at once
	task automatic t_tie;
		logic lo_seen;
		lo_seen = 1'b0;
		apb(1'b1, hbfs_pkg::OFS_CTRL, 32'h7);
		for (int i = 0; i < 2000 && hi_d !== 1'b1; i++) begin
			@(posedge pclk);
			lo_seen = lo_seen | lo_d;
		end
		chk({31'h0, hi_d}, 32'h1);
		chk({31'h0, lo_seen}, 32'h0);
		apb(1'b1, hbfs_pkg::OFS_CTRL, 32'h6);
		repeat (2) @(posedge pclk);
		chk({30'h0, hi_d, lo_d}, 32'h0);
	endtask

	task automatic t_unmapped;
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_rel = $time;
		t_startup();
		t_deadtime();
		t_fault();
		t_tie();
		t_unmapped();
		summarize();
	end

	// Whole run needs a few thousand cycles; far longer means a hang
	initial begin
		#(4 * 20000);
		err_count++;
		summarize();
	end
endmodule // hbfs_host_tb

`default_nettype wire
